//--- vt_filter_ctrl.sv
/*
 * Voltage/temperature converter control and shared decimation filter
 * control, with an output-period timer that paces results and settling.
 * Assumes a single-cycle register port synchronous to core_clk_i and
 * analog modulators that obey the decoded control outputs.
 */
// Our own choice: the plain strobed port.
// Overview of operation
// - Control bit 15 enables converter; clearing it powers the converter down.
// - Bits 14:13 pick excitation sources: none, temp pin, switched ground, both.
// - Bit 9 set gives unipolar coding, clear gives twos complement.
// - Input select routes battery and short to voltage, temps to temperature.
// - Battery input selected automatically enables the attenuator buffers.
// - Bits 5:4 pick reference; supply-half grounds differ per channel.
// - Any filter write that changes its value resets both converters.
// - Filter bit 15 chops; rate drops by three when averaging zero.
// - Bit 14 running average, forced on while chopping, adds settling.
// - Bits 13:8 hold averaging factor for the postfilter.
// - Bit 7 adds a second notch to the sinc3 response.
// - Bits 6:0 set decimation; period is (factor plus one) times 64.
// - Factor 126 forces 60 Hz, factor 127 forces 50 Hz.
// - Low power modes clock the filter from the slow oscillator.
`timescale 1ns/1ps
`include "vt_filter_regs.svh"

module vt_filter_ctrl
  import vt_filter_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Power mode
  input wire logic low_power_i,
  // Converter control
  output logic vt_enable_o,
  output logic exc_temp_pin_o,
  output logic exc_switched_ground_o,
  output logic unipolar_o,
  output input_sel_t input_sel_o,
  output logic route_temp_o,
  output logic atten_buf_en_o,
  output ref_sel_t ref_sel_o,
  output logic ref_gnd_switched_o,
  // Filter control
  output logic cur_adc_reset_o,
  output logic vt_adc_reset_o,
  output logic chop_en_o,
  output logic run_avg_o,
  output logic [5:0] averaging_factor_o,
  output logic second_notch_o,
  output logic [6:0] decimation_ratio_o,
  output logic slow_filter_clk_o,
  // Result pacing
  output logic result_valid_o,
  output logic settled_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [20:0] period_of(input logic [6:0] sf, input logic [5:0] af,
                                            input logic chop);
    logic [20:0] base;
    logic [20:0] mul;
    base = 21'((21'(sf) + 21'h1) * `SF_STEP);
    mul = 21'(af) + `AF_OFFSET;
    if (sf == `SF_FORCE_60) begin
      period_of = `PERIOD_60;
    end else if (sf == `SF_FORCE_50) begin
      period_of = `PERIOD_50;
    end else if (chop) begin
      period_of = 21'(base * mul) + `CHOP_EXTRA;
    end else if (af != 6'h00) begin
      period_of = 21'(base * mul);
    end else begin
      period_of = base;
    end
  endfunction : period_of

  function automatic logic [2:0] settle_of(input logic [5:0] af, input logic chop,
                                           input logic ravg);
    if (chop) begin
      settle_of = `SETTLE_CHOP;
    end else if (af != 6'h00) begin
      settle_of = ravg ? `SETTLE_AF_RAVG : `SETTLE_AF;
    end else begin
      settle_of = ravg ? `SETTLE_PLAIN_RAVG : `SETTLE_PLAIN;
    end
  endfunction : settle_of

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] vt_ctrl_q;
  logic [15:0] flt_ctrl_q;
  logic vt_hit;
  logic flt_hit;
  logic flt_change;
  assign vt_hit = (addr_i == `VT_CTRL_ADDR);
  assign flt_hit = (addr_i == `FLT_CTRL_ADDR);
  assign flt_change = wr_i && flt_hit && (wdata_i != flt_ctrl_q);
  // Reserved bits are not stored, so read-modify-write returns zeros there
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      vt_ctrl_q <= `VT_CTRL_RESET;
    end else if (wr_i && vt_hit) begin
      vt_ctrl_q <= wdata_i & `VT_CTRL_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flt_ctrl_q <= `FLT_CTRL_RESET;
    end else if (wr_i && flt_hit) begin
      flt_ctrl_q <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i && vt_hit) begin
      rdata_o <= vt_ctrl_q;
    end else if (rd_i && flt_hit) begin
      rdata_o <= flt_ctrl_q;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // ****************************************************************
  // Converter decode
  // ****************************************************************
  input_sel_t in_sel;
  ref_sel_t ref_sel;
  logic to_temp;
  assign in_sel = input_sel_t'(vt_ctrl_q[`VT_INSEL_HI:`VT_INSEL_LO]);
  assign ref_sel = ref_sel_t'(vt_ctrl_q[`VT_REF_HI:`VT_REF_LO]);
  assign to_temp = (in_sel == IN_EXT_TEMP) || (in_sel == IN_INT_SENSOR);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      vt_enable_o <= 1'b0;
      exc_temp_pin_o <= 1'b0;
      exc_switched_ground_o <= 1'b0;
      unipolar_o <= 1'b0;
      input_sel_o <= IN_BATTERY;
      route_temp_o <= 1'b0;
      atten_buf_en_o <= 1'b1;
      ref_sel_o <= REF_INTERNAL;
      ref_gnd_switched_o <= 1'b0;
    end else begin
      vt_enable_o <= vt_ctrl_q[`VT_EN_BIT];
      exc_temp_pin_o <= vt_ctrl_q[`VT_EXC_LO];
      exc_switched_ground_o <= vt_ctrl_q[`VT_EXC_HI];
      unipolar_o <= vt_ctrl_q[`VT_CODING_BIT];
      input_sel_o <= in_sel;
      route_temp_o <= to_temp;
      atten_buf_en_o <= (in_sel == IN_BATTERY);
      ref_sel_o <= ref_sel;
      case (ref_sel)
        REF_INTERNAL: ref_gnd_switched_o <= 1'b0;
        REF_SUPPLY_HALF: ref_gnd_switched_o <= to_temp;
        default: ref_gnd_switched_o <= 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // Filter decode
  // ****************************************************************
  logic chop;
  logic [5:0] af;
  logic [6:0] sf;
  assign chop = flt_ctrl_q[`FLT_CHOP_BIT];
  assign af = flt_ctrl_q[`FLT_AF_HI:`FLT_AF_LO];
  assign sf = flt_ctrl_q[`FLT_SF_HI:`FLT_SF_LO];
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cur_adc_reset_o <= 1'b0;
      vt_adc_reset_o <= 1'b0;
      chop_en_o <= 1'b0;
      run_avg_o <= 1'b0;
      averaging_factor_o <= 6'h00;
      second_notch_o <= 1'b0;
      decimation_ratio_o <= 7'h07;
      slow_filter_clk_o <= 1'b0;
    end else begin
      cur_adc_reset_o <= flt_change;
      vt_adc_reset_o <= flt_change;
      chop_en_o <= chop;
      run_avg_o <= flt_ctrl_q[`FLT_RAVG_BIT] | chop;
      averaging_factor_o <= af;
      second_notch_o <= flt_ctrl_q[`FLT_NOTCH_BIT];
      decimation_ratio_o <= sf;
      slow_filter_clk_o <= low_power_i;
    end
  end

  // ****************************************************************
  // Output period timer
  // ****************************************************************
  // Modulator ticks are a divided stand-in for the analog filter clock
  logic [10:0] div_cnt_q;
  logic mod_tick_q;
  logic [10:0] div_max;
  logic [20:0] period_q;
  logic [20:0] per_cnt_q;
  logic [2:0] settle_need_q;
  logic done_q;
  logic restart_q;
  assign div_max = slow_filter_clk_o ? (`LP_DIV_CYC - 11'h1) : (`MOD_DIV_CYC - 11'h1);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      div_cnt_q <= 11'h000;
      mod_tick_q <= 1'b0;
    end else if (div_cnt_q >= div_max) begin
      div_cnt_q <= 11'h000;
      mod_tick_q <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 11'h1;
      mod_tick_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      period_q <= 21'h000200;
      settle_need_q <= `SETTLE_PLAIN;
    end else begin
      period_q <= period_of(sf, af, chop);
      settle_need_q <= settle_of(af, chop, flt_ctrl_q[`FLT_RAVG_BIT]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= flt_change;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || restart_q || !vt_enable_o) begin
      per_cnt_q <= 21'h000000;
      done_q <= 1'b0;
    end else if (mod_tick_q && (per_cnt_q >= period_q - 21'h1)) begin
      per_cnt_q <= 21'h000000;
      done_q <= 1'b1;
    end else begin
      per_cnt_q <= per_cnt_q + 21'(mod_tick_q);
      done_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Settling
  // ****************************************************************
  settle_state_t state_q;
  logic [2:0] settle_cnt_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      settle_cnt_q <= 3'h0;
      result_valid_o <= 1'b0;
      settled_o <= 1'b0;
    end else if (restart_q || !vt_enable_o) begin
      state_q <= vt_enable_o ? ST_SETTLE : ST_IDLE;
      settle_cnt_q <= 3'h0;
      result_valid_o <= 1'b0;
      settled_o <= 1'b0;
    end else begin
      result_valid_o <= 1'b0;
      case (state_q)
        ST_IDLE: state_q <= ST_SETTLE;
        ST_SETTLE: begin
          if (done_q) begin
            settle_cnt_q <= settle_cnt_q + 3'h1;
            if (settle_cnt_q + 3'h1 >= settle_need_q) begin
              state_q <= ST_READY;
              settled_o <= 1'b1;
              result_valid_o <= 1'b1;
            end
          end
        end
        ST_READY: result_valid_o <= done_q;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  enable_write_a: assert property (
    wr_i && vt_hit |-> ##2 vt_enable_o == $past(wdata_i[`VT_EN_BIT], 2))
    else $error("enable output does not follow control write");
  excitation_write_a: assert property (
    wr_i && vt_hit |-> ##2
      {exc_switched_ground_o, exc_temp_pin_o} == $past(wdata_i[`VT_EXC_HI:`VT_EXC_LO], 2))
    else $error("excitation outputs do not follow control write");
  coding_write_a: assert property (
    wr_i && vt_hit |-> ##2 unipolar_o == $past(wdata_i[`VT_CODING_BIT], 2))
    else $error("coding output does not follow control write");
  result_route_a: assert property (
    route_temp_o == (input_sel_o == IN_EXT_TEMP || input_sel_o == IN_INT_SENSOR))
    else $error("result routing mismatches input select");
  atten_buffer_a: assert property (
    atten_buf_en_o == (input_sel_o == IN_BATTERY))
    else $error("attenuator buffers not tied to battery input");
  supply_ground_a: assert property (
    ref_sel_o == REF_SUPPLY_HALF |-> ref_gnd_switched_o == route_temp_o)
    else $error("supply-half ground return wrong for channel");
  filter_reset_a: assert property (
    wr_i && flt_hit |=> (cur_adc_reset_o && vt_adc_reset_o) == $past(wdata_i != flt_ctrl_q))
    else $error("converter reset does not match filter change");
  chop_avg_a: assert property (
    chop_en_o |-> run_avg_o)
    else $error("running average not forced by chop");
  forced_rate_a: assert property (
    $past(sf) == `SF_FORCE_60 |-> period_q == `PERIOD_60)
    else $error("factor 126 does not force the 60 Hz period");
  chop_settle_a: assert property (
    $past(chop) |-> settle_need_q == `SETTLE_CHOP)
    else $error("chop settling is not two periods");
  plain_settle_a: assert property (
    $past(!chop && af == 6'h00 && !flt_ctrl_q[`FLT_RAVG_BIT]) |-> settle_need_q == `SETTLE_PLAIN)
    else $error("plain settling is not three periods");
  tick_spacing_a: assert property (
    mod_tick_q |=> !mod_tick_q [*8])
    else $error("modulator ticks too close together");
  settled_cover: cover property (settled_o && result_valid_o);
  forced_cover: cover property (sf == `SF_FORCE_50 && done_q);
  chop_cover: cover property (chop_en_o && settled_o);
  low_power_cover: cover property (slow_filter_clk_o && mod_tick_q);
endmodule : vt_filter_ctrl

//--- vt_filter_regs.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * voltage/temperature converter control and the decimation filter control.
 * Assumes a 250 MHz core clock.
 */
`ifndef VT_FILTER_REGS_SVH
`define VT_FILTER_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define VT_CTRL_ADDR 32'hffff0510
`define FLT_CTRL_ADDR 32'hffff0518
`define VT_CTRL_RESET 16'h0000
`define FLT_CTRL_RESET 16'h0007
// Implemented bits of the control word; reserved ones read as zero
`define VT_CTRL_MASK 16'he2f0

// ****************************************************************
// Field positions
// ****************************************************************
`define VT_EN_BIT 15
`define VT_EXC_HI 14
`define VT_EXC_LO 13
`define VT_CODING_BIT 9
`define VT_INSEL_HI 7
`define VT_INSEL_LO 6
`define VT_REF_HI 5
`define VT_REF_LO 4
`define FLT_CHOP_BIT 15
`define FLT_RAVG_BIT 14
`define FLT_AF_HI 13
`define FLT_AF_LO 8
`define FLT_NOTCH_BIT 7
`define FLT_SF_HI 6
`define FLT_SF_LO 0
`define SF_FORCE_60 7'h7e
`define SF_FORCE_50 7'h7f

// ****************************************************************
// Timing
// ****************************************************************
`define CORE_CLK_HZ 250000000
`define MOD_CLK_HZ 512000
`define LP_OSC_HZ 131000
`define RATE_60_HZ 60
`define RATE_50_HZ 50
`define MOD_DIV_CYC 11'(`CORE_CLK_HZ / `MOD_CLK_HZ)
`define LP_DIV_CYC 11'(`CORE_CLK_HZ / `LP_OSC_HZ)
`define PERIOD_60 21'(`MOD_CLK_HZ / `RATE_60_HZ)
`define PERIOD_50 21'(`MOD_CLK_HZ / `RATE_50_HZ)
`define SF_STEP 21'h40
`define AF_OFFSET 21'h3
`define CHOP_EXTRA 21'h3
`define SETTLE_CHOP 3'h2
`define SETTLE_AF 3'h1
`define SETTLE_AF_RAVG 3'h2
`define SETTLE_PLAIN 3'h3
`define SETTLE_PLAIN_RAVG 3'h4

`endif

//--- vt_filter_pkg.sv
/*
 * Types shared by the converter control block.
 * Assumes the register header is included by the design file.
 */
package vt_filter_pkg;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic [1:0] {
    IN_BATTERY = 2'b00,
    IN_EXT_TEMP = 2'b01,
    IN_INT_SENSOR = 2'b10,
    IN_SHORT = 2'b11
  } input_sel_t;

  typedef enum logic [1:0] {
    REF_INTERNAL = 2'b00,
    REF_EXTERNAL = 2'b01,
    REF_EXT_HALF = 2'b10,
    REF_SUPPLY_HALF = 2'b11
  } ref_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_READY = 2'b10
  } settle_state_t;

endpackage : vt_filter_pkg

//--- vt_analog_model.sv
/*
 * Behavioural far-side model of the analog modulators: counts the converter
 * restarts it is ordered to perform and tracks which result register the
 * next result is steered to.
 * Assumes it watches the decoded control outputs of the converter block.
 */
`timescale 1ns/1ps

module vt_analog_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Controls from the block
  input wire logic vt_adc_reset_i,
  input wire logic cur_adc_reset_i,
  input wire logic route_temp_i,
  // Observed state
  output logic [7:0] restart_cnt_o,
  output logic temp_target_o
);
  logic [7:0] restart_q;
  logic temp_target_q;

  // ****************************************************************
  // Restart bookkeeping
  // ****************************************************************
  // Both converters restart
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      restart_q <= 8'h00;
    end else if (vt_adc_reset_i && cur_adc_reset_i) begin
      restart_q <= restart_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      temp_target_q <= 1'b0;
    end else begin
      temp_target_q <= route_temp_i;
    end
  end

  assign restart_cnt_o = restart_q;
  assign temp_target_o = temp_target_q;
endmodule : vt_analog_model

//--- adc_voltage_temp_and_filter_control_test.sv
/*
 * Self-checking bench for the converter and filter control block.
 * Assumes the single-cycle register port and one 250 MHz clock.
 */
`timescale 1ns/1ps
`include "vt_filter_regs.svh"

module adc_voltage_temp_and_filter_control_test
  import vt_filter_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic low_power = 1'b0;
  logic [15:0] rdata;
  logic vt_en, exc_temp, exc_gnd, unipolar, route_temp, atten, ref_gnd;
  input_sel_t in_sel;
  ref_sel_t ref_sel;
  logic cur_rst, vt_rst, chop, ravg, notch, slow_clk, res_valid, settled, temp_tgt;
  logic [5:0] af;
  logic [6:0] dec;
  logic [7:0] restarts;
  int err_count = 0;
  int n_checks = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  vt_filter_ctrl dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .low_power_i(low_power), .vt_enable_o(vt_en),
    .exc_temp_pin_o(exc_temp), .exc_switched_ground_o(exc_gnd), .unipolar_o(unipolar),
    .input_sel_o(in_sel), .route_temp_o(route_temp), .atten_buf_en_o(atten),
    .ref_sel_o(ref_sel), .ref_gnd_switched_o(ref_gnd), .cur_adc_reset_o(cur_rst),
    .vt_adc_reset_o(vt_rst), .chop_en_o(chop), .run_avg_o(ravg),
    .averaging_factor_o(af), .second_notch_o(notch), .decimation_ratio_o(dec),
    .slow_filter_clk_o(slow_clk), .result_valid_o(res_valid), .settled_o(settled)
  );

  vt_analog_model model (
    .core_clk_i(clk), .rst_n_i(rst_n), .vt_adc_reset_i(vt_rst),
    .cur_adc_reset_i(cur_rst), .route_temp_i(route_temp),
    .restart_cnt_o(restarts), .temp_target_o(temp_tgt)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus_write(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_write

  // Read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [31:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_read

  task automatic read_check(input string name, input logic [31:0] a, input logic [15:0] e);
    logic [15:0] d;
    bus_read(a, d);
    check(name, d, e);
  endtask : read_check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    #1;
    check("dec reset", dec, 16'h0007);
    check("atten reset", atten, 16'h0001);
    check("enable reset", vt_en, 16'h0000);
    read_check("vt reset", `VT_CTRL_ADDR, `VT_CTRL_RESET);
    @(posedge clk);
    #1 check("rdata idle", rdata, 16'h0000);
    read_check("flt reset", `FLT_CTRL_ADDR, `FLT_CTRL_RESET);
    read_check("unmapped", 32'hffff0514, 16'h0000);
  endtask : test_reset

  // Every input, reference and excitation code, with coding alternating
  task automatic test_vt_fields;
    logic [1:0] s, r, x;
    logic [15:0] w;
    logic rt;
    for (int i = 0; i < 16; i++) begin
      s = i[1:0];
      r = i[3:2];
      x = s ^ r;
      w = {1'b1, x, 3'b000, i[0], 1'b0, s, r, 4'h0};
      rt = (s == 2'b01) || (s == 2'b10);
      bus_write(`VT_CTRL_ADDR, w);
      @(posedge clk);
      #1;
      check("enable", vt_en, 16'h0001);
      check("exc temp", exc_temp, x[0]);
      check("exc gnd", exc_gnd, x[1]);
      check("unipolar", unipolar, i[0]);
      check("input", in_sel, s);
      check("route", route_temp, rt);
      check("atten", atten, s == 2'b00);
      check("ref", ref_sel, r);
      check("ref gnd", ref_gnd, (r == 2'b00) ? 1'b0 : ((r == 2'b11) ? rt : 1'b1));
      read_check("vt readback", `VT_CTRL_ADDR, w);
      check("model route", temp_tgt, rt);
    end
    bus_write(`VT_CTRL_ADDR, 16'h0000);
    bus_write(32'hffff0514, 16'hffff);
    @(posedge clk);
    #1;
    check("disabled", vt_en, 16'h0000);
    check("exc off", {exc_temp, exc_gnd}, 16'h0000);
    read_check("vt kept", `VT_CTRL_ADDR, 16'h0000);
  endtask : test_vt_fields

  // Changed values restart both converters; a repeated value does not
  task automatic test_filter;
    logic [15:0] tbl [4];
    logic [7:0] n;
    tbl = '{16'h8580, 16'h8580, 16'h407e, 16'h40ff};
    n = 8'h00;
    for (int i = 0; i < 4; i++) begin
      bus_write(`FLT_CTRL_ADDR, tbl[i]);
      if (i != 1) begin
        n = n + 8'h01;
      end
      #1 check("restart pulse", {cur_rst, vt_rst}, (i != 1) ? 16'h0003 : 16'h0000);
      @(posedge clk);
      #1;
      check("restart end", {cur_rst, vt_rst}, 16'h0000);
      check("chop", chop, tbl[i][15]);
      check("run avg", ravg, tbl[i][15] | tbl[i][14]);
      check("af", af, tbl[i][13:8]);
      check("notch", notch, tbl[i][7]);
      check("dec", dec, tbl[i][6:0]);
      read_check("flt readback", `FLT_CTRL_ADDR, tbl[i]);
    end
    check("restarts", restarts, n);
  endtask : test_filter

  // Plain filter at factor 0 settles after three periods of 64 ticks; tick phase adds slack
  task automatic test_settling;
    int cnt;
    int lo;
    int hi;
    cnt = 0;
    lo = (3 * 64 - 1) * `MOD_DIV_CYC;
    hi = 3 * 64 * `MOD_DIV_CYC + 4;
    bus_write(`VT_CTRL_ADDR, 16'h8000);
    bus_write(`FLT_CTRL_ADDR, 16'h0000);
    while (settled !== 1'b1 && cnt <= hi) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check("early results", cnt >= lo, 16'h0001);
    check("late settling", cnt <= hi, 16'h0001);
    check("first result", res_valid, 16'h0001);
  endtask : test_settling

  task automatic test_low_power;
    #1 check("fast clock", slow_clk, 16'h0000);
    @(posedge clk);
    low_power <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("slow clock", slow_clk, 16'h0001);
    @(posedge clk);
    low_power <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check("fast again", slow_clk, 16'h0000);
  endtask : test_low_power

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_reset();
    test_vt_fields();
    test_filter();
    test_settling();
    test_low_power();
    report_and_stop();
  end

  // Settling wait dominates the run; this bound stays inside the cycle budget
  initial begin
    #390000;
    err_count++;
    report_and_stop();
  end
endmodule : adc_voltage_temp_and_filter_control_test
